/* File: hw/clk_mode_pkg.sv */
package clk_mode_pkg;
    // Register indices on the plain register port
    localparam logic [1:0] ADDR_SYS_CLK_CTRL = 2'h0;
    localparam logic [1:0] ADDR_INT_FAST_CTRL = 2'h1;
    localparam logic [1:0] ADDR_EXT_FAST_CTRL = 2'h2;
    localparam logic [1:0] ADDR_EXT_SLOW_CTRL = 2'h3;
    // System clock control fields
    localparam int SEL_HI = 7;
    localparam int SEL_LO = 5;
    localparam int FAST_SRC_BIT = 3;
    localparam int SLOW_SRC_BIT = 2;
    localparam int FAST_IDLE_BIT = 1;
    localparam int SLOW_IDLE_BIT = 0;
    // Oscillator control fields, and the select code for slow mode
    localparam int OSC_EN_BIT = 0;
    localparam int OSC_RDY_BIT = 1;
    localparam int FREQ_HI = 3;
    localparam int FREQ_LO = 2;
    localparam int OSC_MODE_BIT = 2;
    localparam logic [2:0] SEL_SLOW = 3'h7;
    // Reset values
    localparam logic [7:0] SYS_CLK_CTRL_RST = 8'h00;
    localparam logic [7:0] INT_FAST_CTRL_RST = 8'h01;
    localparam logic [7:0] EXT_FAST_CTRL_RST = 8'h00;
    localparam logic [7:0] EXT_SLOW_CTRL_RST = 8'h00;
    // Crystal start-up delays
    localparam int CLK_MHZ = 125;
    localparam int SLOW_XTAL_START_US = 8;
    localparam int SLOW_XTAL_START_CYC = SLOW_XTAL_START_US * CLK_MHZ;
    localparam int FAST_XTAL_START_CYC = 16;
    localparam int CNT_W = 11;
    // Operating modes
    typedef enum logic [2:0] {
        MODE_FAST = 3'h0,
        MODE_SLOW = 3'h1,
        MODE_SLEEP = 3'h3,
        MODE_IDLE_SLOW_ONLY = 3'h2,
        MODE_IDLE_BOTH_CLOCKS = 3'h6,
        MODE_IDLE_FAST_ONLY = 3'h7
    } op_mode_t;
endpackage : clk_mode_pkg

/* File: hw/osc_start_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Start-up timer: ready rises a fixed count after enable, drops at once on disable
module osc_start_timer #(
    parameter int COUNT = 16
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    output logic ready
);
    import clk_mode_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic rdy;
    } timer_state_t;

    timer_state_t state_reg;
    timer_state_t state_next;

    localparam logic [CNT_W-1:0] LAST = CNT_W'(COUNT - 1);

    // Count while enabled; a disable restarts the wait
    always_comb begin
        state_next = state_reg;
        if (!enable) begin
            state_next.cnt = '0;
            state_next.rdy = 1'b0;
        end else if (!state_reg.rdy) begin
            if (state_reg.cnt == LAST) begin
                state_next.rdy = 1'b1;
            end else begin
                state_next.cnt = state_reg.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign ready = state_reg.rdy;
endmodule : osc_start_timer
`default_nettype wire

/* File: hw/clk_divider.sv */
`timescale 1ns/1ps
`default_nettype none
// Divides by 2**ratio_sel as a one-cycle enable, except code 7 which divides by 64; code 0 passes every cycle
module clk_divider (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [2:0] ratio_sel,
    output logic tick
);
    typedef struct packed {
        logic [5:0] cnt;
        logic tick;
    } div_state_t;

    div_state_t state_reg;
    div_state_t state_next;
    logic [5:0] last;

    // Terminal count follows the select so a ratio change takes effect at once
    always_comb begin
        last = 6'((7'h01 << ratio_sel) - 7'h01);
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (!run) begin
            state_next.cnt = '0;
        end else if (state_reg.cnt >= last) begin
            state_next.cnt = '0;
            state_next.tick = 1'b1;
        end else begin
            state_next.cnt = state_reg.cnt + 6'h01;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick = state_reg.tick;
endmodule : clk_divider

/* File: hw/op_mode_clock_ctrl.sv */
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Six modes: fast, slow running; sleep and three idle modes stop CPU.
// - Fast mode: system clock is fast clock divided 1..64 by select 000..110.
// - Select 111 gives slow mode, CPU on the low-speed sub clock.
// - Fast clock source is fast crystal or internal fast RC, by source bit.
// - Sub clock source is internal slow RC or slow crystal, by source bit.
// - In slow mode fast clock follows the selected oscillator's enable bit.
// - Halt with both idle enables low: sleep, CPU, fast and sub clocks off.
// - In sleep the low-frequency RC clock runs only while watchdog enabled.
// - Halt with fast idle low, slow idle high: CPU off, only sub clock.
// - Halt with both idle enables high: CPU off, all clocks keep running.
// - Halt with fast idle high, slow idle low: CPU and sub clock off.
// - System control: select 7:5, bit 4 unused, sources 3:2, idles 1:0.
// - Oscillator registers: bit 0 enable, bit 1 ready, extra field bits above.
// - Slow crystal is usable only after a start-up delay from enable.
module op_mode_clock_ctrl (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic halt_req,
    input wire logic wake_req,
    input wire logic watchdog_enable,
    output clk_mode_pkg::op_mode_t op_mode,
    output logic cpu_clk_en,
    output logic sys_clk_tick,
    output logic sys_on_sub,
    output logic fast_clk_en,
    output logic fast_from_crystal,
    output logic sub_clk_en,
    output logic sub_from_crystal,
    output logic low_freq_rc_clock_en,
    output logic internal_fast_en,
    output logic external_fast_crystal_en,
    output logic external_slow_crystal_en,
    output logic [1:0] internal_fast_freq_select
);
    import clk_mode_pkg::*;

    typedef struct packed {
        logic [7:0] sys_ctrl;
        logic [7:0] ifast_ctrl;
        logic [7:0] xfast_ctrl;
        logic [7:0] xslow_ctrl;
        logic [7:0] rdata;
        op_mode_t mode;
        logic [2:0] held_sel;
        logic cpu_en;
        logic tick;
        logic on_sub;
        logic fast_en;
        logic fast_xtal;
        logic sub_en;
        logic sub_xtal;
        logic internal_slow_rc_osc_en;
        logic ifast_en;
        logic xfast_en;
        logic xslow_en;
        logic [1:0] freq_sel;
    } ctrl_state_t;

    ctrl_state_t state_reg;
    ctrl_state_t state_next;

    logic ifast_ready;
    logic xfast_ready;
    logic xslow_ready;
    logic div_tick;
    logic fast_src_ready;
    logic sub_src_ready;
    logic [2:0] sel;
    logic running;

    assign sel = state_reg.sys_ctrl[SEL_HI:SEL_LO];
    assign running = (state_reg.mode == MODE_FAST) || (state_reg.mode == MODE_SLOW);

    // Oscillator start-up; the internal RC settles quickly
    osc_start_timer #(.COUNT(2)) u_ifast_timer (
        .clock(clock),
        .rst_n(rst_n),
        .enable(state_reg.ifast_ctrl[OSC_EN_BIT]),
        .ready(ifast_ready)
    );

    osc_start_timer #(.COUNT(FAST_XTAL_START_CYC)) u_xfast_timer (
        .clock(clock),
        .rst_n(rst_n),
        .enable(state_reg.xfast_ctrl[OSC_EN_BIT]),
        .ready(xfast_ready)
    );

    osc_start_timer #(.COUNT(SLOW_XTAL_START_CYC)) u_xslow_timer (
        .clock(clock),
        .rst_n(rst_n),
        .enable(state_reg.xslow_ctrl[OSC_EN_BIT]),
        .ready(xslow_ready)
    );

    // Divider only runs in fast mode with the CPU clocked
    clk_divider u_div (
        .clock(clock),
        .rst_n(rst_n),
        .run(state_reg.mode == MODE_FAST && sel != SEL_SLOW),
        .ratio_sel(sel),
        .tick(div_tick)
    );

    // Internal slow RC always counts as ready; the crystal waits out its start-up
    assign fast_src_ready = state_reg.sys_ctrl[FAST_SRC_BIT] ? ifast_ready : xfast_ready;
    assign sub_src_ready = state_reg.sys_ctrl[SLOW_SRC_BIT] ? 1'b1 : xslow_ready;

    // Registers, mode sequencing and gating, all in one next-state pass
    always_comb begin
        state_next = state_reg;
        state_next.rdata = 8'h00;
        // Register writes; ready flags and unused bits are not writable
        if (reg_write) begin
            unique case (reg_addr)
                ADDR_SYS_CLK_CTRL: begin
                    state_next.sys_ctrl = reg_wdata & 8'hEF;
                end
                ADDR_INT_FAST_CTRL: begin
                    state_next.ifast_ctrl = {4'h0, reg_wdata[FREQ_HI:FREQ_LO], 1'b0,
                        reg_wdata[OSC_EN_BIT]};
                end
                ADDR_EXT_FAST_CTRL: begin
                    state_next.xfast_ctrl = {5'h00, reg_wdata[OSC_MODE_BIT], 1'b0,
                        reg_wdata[OSC_EN_BIT]};
                end
                ADDR_EXT_SLOW_CTRL: begin
                    state_next.xslow_ctrl = {5'h00, reg_wdata[OSC_MODE_BIT], 1'b0,
                        reg_wdata[OSC_EN_BIT]};
                end
            endcase
        end
        // Reads show live ready flags, one cycle later
        if (reg_read) begin
            unique case (reg_addr)
                ADDR_SYS_CLK_CTRL: state_next.rdata = state_reg.sys_ctrl;
                ADDR_INT_FAST_CTRL: state_next.rdata = state_reg.ifast_ctrl | {6'h00, ifast_ready, 1'b0};
                ADDR_EXT_FAST_CTRL: state_next.rdata = state_reg.xfast_ctrl | {6'h00, xfast_ready, 1'b0};
                ADDR_EXT_SLOW_CTRL: state_next.rdata = state_reg.xslow_ctrl | {6'h00, xslow_ready, 1'b0};
            endcase
        end

        // Mode: halt samples the idle enables and select; wake returns to running
        if (running) begin
            state_next.mode = (sel == SEL_SLOW) ? MODE_SLOW : MODE_FAST;
            if (halt_req) begin
                state_next.held_sel = sel;
                unique case (state_reg.sys_ctrl[FAST_IDLE_BIT:SLOW_IDLE_BIT])
                    2'b00: state_next.mode = MODE_SLEEP;
                    2'b01: state_next.mode = MODE_IDLE_SLOW_ONLY;
                    2'b11: state_next.mode = MODE_IDLE_BOTH_CLOCKS;
                    2'b10: state_next.mode = MODE_IDLE_FAST_ONLY;
                endcase
            end
        end else if (wake_req) begin
            state_next.mode = (sel == SEL_SLOW) ? MODE_SLOW : MODE_FAST;
        end

        // Clock gating per next mode
        state_next.cpu_en = 1'b0;
        state_next.on_sub = 1'b0;
        state_next.fast_en = 1'b0;
        state_next.sub_en = 1'b0;
        state_next.internal_slow_rc_osc_en = 1'b1;
        unique case (state_next.mode)
            MODE_FAST: begin
                state_next.cpu_en = 1'b1;
                state_next.fast_en = 1'b1;
                state_next.sub_en = 1'b1;
            end
            MODE_SLOW: begin
                state_next.cpu_en = 1'b1;
                state_next.on_sub = 1'b1;
                // Fast clock left to the selected oscillator's enable
                state_next.fast_en = state_reg.sys_ctrl[FAST_SRC_BIT] ?
                    state_reg.ifast_ctrl[OSC_EN_BIT] : state_reg.xfast_ctrl[OSC_EN_BIT];
                state_next.sub_en = 1'b1;
            end
            MODE_SLEEP: begin
                state_next.internal_slow_rc_osc_en = watchdog_enable;
            end
            MODE_IDLE_SLOW_ONLY: begin
                state_next.sub_en = 1'b1;
            end
            MODE_IDLE_BOTH_CLOCKS: begin
                state_next.fast_en = 1'b1;
                state_next.sub_en = 1'b1;
            end
            MODE_IDLE_FAST_ONLY: begin
                state_next.fast_en = 1'b1;
            end
        endcase
        // A gated clock is only passed on once its source is ready
        state_next.fast_en = state_next.fast_en & fast_src_ready;
        state_next.sub_en = state_next.sub_en & sub_src_ready;
        state_next.fast_xtal = ~state_reg.sys_ctrl[FAST_SRC_BIT];
        state_next.sub_xtal = ~state_reg.sys_ctrl[SLOW_SRC_BIT];
        state_next.tick = running && (sel != SEL_SLOW) && div_tick;
        state_next.ifast_en = state_reg.ifast_ctrl[OSC_EN_BIT];
        state_next.xfast_en = state_reg.xfast_ctrl[OSC_EN_BIT];
        state_next.xslow_en = state_reg.xslow_ctrl[OSC_EN_BIT];
        state_next.freq_sel = state_reg.ifast_ctrl[FREQ_HI:FREQ_LO];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
            state_reg.sys_ctrl <= SYS_CLK_CTRL_RST;
            state_reg.ifast_ctrl <= INT_FAST_CTRL_RST;
            state_reg.xfast_ctrl <= EXT_FAST_CTRL_RST;
            state_reg.xslow_ctrl <= EXT_SLOW_CTRL_RST;
            state_reg.mode <= MODE_FAST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata = state_reg.rdata;
    assign op_mode = state_reg.mode;
    assign cpu_clk_en = state_reg.cpu_en;
    assign sys_clk_tick = state_reg.tick;
    assign sys_on_sub = state_reg.on_sub;
    assign fast_clk_en = state_reg.fast_en;
    assign fast_from_crystal = state_reg.fast_xtal;
    assign sub_clk_en = state_reg.sub_en;
    assign sub_from_crystal = state_reg.sub_xtal;
    assign low_freq_rc_clock_en = state_reg.internal_slow_rc_osc_en;
    assign internal_fast_en = state_reg.ifast_en;
    assign external_fast_crystal_en = state_reg.xfast_en;
    assign external_slow_crystal_en = state_reg.xslow_en;
    assign internal_fast_freq_select = state_reg.freq_sel;

    // Halt with both idle enables low lands in sleep next cycle
    a_sleep_entry: assert property (@(posedge clock) disable iff (!rst_n)
        running && halt_req && state_reg.sys_ctrl[1:0] == 2'b00 |=> op_mode == MODE_SLEEP)
        else $error("sleep not entered");
    a_idle_slow: assert property (@(posedge clock) disable iff (!rst_n)
        running && halt_req && state_reg.sys_ctrl[1:0] == 2'b01
        |=> op_mode == MODE_IDLE_SLOW_ONLY && !fast_clk_en)
        else $error("idle slow-only wrong");
    a_idle_both: assert property (@(posedge clock) disable iff (!rst_n)
        running && halt_req && state_reg.sys_ctrl[1:0] == 2'b11
        |=> op_mode == MODE_IDLE_BOTH_CLOCKS && low_freq_rc_clock_en)
        else $error("idle both wrong");
    a_idle_fast: assert property (@(posedge clock) disable iff (!rst_n)
        running && halt_req && state_reg.sys_ctrl[1:0] == 2'b10
        |=> op_mode == MODE_IDLE_FAST_ONLY && !sub_clk_en)
        else $error("idle fast-only wrong");
    a_cpu_off: assert property (@(posedge clock) disable iff (!rst_n)
        (op_mode != MODE_FAST && op_mode != MODE_SLOW) |-> !cpu_clk_en)
        else $error("cpu clocked while halted");
    a_sleep_internal_slow_rc_osc: assert property (@(posedge clock) disable iff (!rst_n)
        op_mode == MODE_SLEEP && $past(state_next.mode) == MODE_SLEEP
        |-> low_freq_rc_clock_en == $past(watchdog_enable))
        else $error("sleep low-freq clock wrong");
    a_slow_select: assert property (@(posedge clock) disable iff (!rst_n)
        running && !halt_req && sel == SEL_SLOW |=> sys_on_sub && !sys_clk_tick)
        else $error("slow mode not on sub clock");
    a_sleep_gates: assert property (@(posedge clock) disable iff (!rst_n)
        op_mode == MODE_SLEEP |-> !fast_clk_en && !sub_clk_en)
        else $error("clocks on in sleep");
    a_xtal_delay: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(state_reg.xslow_ctrl[0]) |-> !xslow_ready [*8])
        else $error("slow crystal ready too early");
    a_unused_bit: assert property (@(posedge clock) disable iff (!rst_n)
        !state_reg.sys_ctrl[4])
        else $error("unused bit set");

    // Fast mode clocks the CPU straight from the divided fast clock
    a_fast_mode: assert property (@(posedge clock) disable iff (!rst_n)
        $past(rst_n) && op_mode == MODE_FAST |-> cpu_clk_en && !sys_on_sub)
        else $error("fast mode gating wrong");

    // Slow mode runs the CPU on the sub clock, no divided ticks
    a_slow_mode: assert property (@(posedge clock) disable iff (!rst_n)
        op_mode == MODE_SLOW |-> cpu_clk_en && sys_on_sub && !sys_clk_tick)
        else $error("slow mode gating wrong");

    // Source flags track the inverted source bits one cycle late
    a_fast_source: assert property (@(posedge clock) disable iff (!rst_n)
        $past(rst_n) |-> fast_from_crystal == !$past(state_reg.sys_ctrl[FAST_SRC_BIT]))
        else $error("fast source flag wrong");

    a_sub_source: assert property (@(posedge clock) disable iff (!rst_n)
        $past(rst_n) |-> sub_from_crystal == !$past(state_reg.sys_ctrl[SLOW_SRC_BIT]))
        else $error("sub source flag wrong");

    // In slow mode the fast clock is left to the chosen oscillator's enable
    a_slow_fast_clk: assert property (@(posedge clock) disable iff (!rst_n)
        op_mode == MODE_SLOW |-> fast_clk_en == ($past(fast_src_ready) &&
        $past(state_reg.sys_ctrl[FAST_SRC_BIT] ? state_reg.ifast_ctrl[OSC_EN_BIT] :
        state_reg.xfast_ctrl[OSC_EN_BIT])))
        else $error("slow mode fast clock wrong");

    // Low-frequency RC only stops in sleep, apart from the first cycle out of reset, which loads it off
    a_internal_slow_rc_osc_awake: assert property (@(posedge clock) disable iff (!rst_n)
        $past(rst_n) && op_mode != MODE_SLEEP |-> low_freq_rc_clock_en)
        else $error("low-freq clock off outside sleep");

    // A halt while halted must not move the mode
    a_halt_held: assert property (@(posedge clock) disable iff (!rst_n)
        !running && halt_req && !wake_req |=> op_mode == $past(op_mode))
        else $error("mode moved on repeated halt");

    // Wake always lands in a running mode with the CPU clocked
    a_wake_return: assert property (@(posedge clock) disable iff (!rst_n)
        !running && wake_req |=> (op_mode == MODE_FAST || op_mode == MODE_SLOW) && cpu_clk_en)
        else $error("wake did not resume");

    // Frequency field and internal enable reach their pins one cycle late
    a_freq_follow: assert property (@(posedge clock) disable iff (!rst_n)
        $past(rst_n) |-> internal_fast_freq_select == $past(state_reg.ifast_ctrl[FREQ_HI:FREQ_LO]))
        else $error("frequency select wrong");

    a_ifast_enable: assert property (@(posedge clock) disable iff (!rst_n)
        $past(rst_n) |-> internal_fast_en == $past(state_reg.ifast_ctrl[OSC_EN_BIT]))
        else $error("internal fast enable wrong");
endmodule : op_mode_clock_ctrl
`default_nettype wire

/* File: verification/test_op_mode_clock_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module test_op_mode_clock_ctrl;
    import clk_mode_pkg::*;
    // Run needs under two thousand cycles; ceiling leaves wide margin
    localparam int LIMIT = 20000;
    logic clock;
    logic rst_n;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    logic [7:0] reg_rdata;
    logic halt_req;
    logic wake_req;
    logic watchdog_enable;
    op_mode_t op_mode;
    logic cpu_clk_en;
    logic sys_clk_tick;
    logic sys_on_sub;
    logic fast_clk_en;
    logic fast_from_crystal;
    logic sub_clk_en;
    logic sub_from_crystal;
    logic low_freq_rc_clock_en;
    logic internal_fast_en;
    logic external_fast_crystal_en;
    logic external_slow_crystal_en;
    logic [1:0] internal_fast_freq_select;
    logic [7:0] rd_exp[$];
    logic rd_pend = 1'b0;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    op_mode_t exp_mode [4] = '{MODE_SLEEP, MODE_IDLE_SLOW_ONLY, MODE_IDLE_FAST_ONLY,
        MODE_IDLE_BOTH_CLOCKS};

    op_mode_clock_ctrl u_op_mode_clock_ctrl (
        .clock(clock),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .halt_req(halt_req),
        .wake_req(wake_req),
        .watchdog_enable(watchdog_enable),
        .op_mode(op_mode),
        .cpu_clk_en(cpu_clk_en),
        .sys_clk_tick(sys_clk_tick),
        .sys_on_sub(sys_on_sub),
        .fast_clk_en(fast_clk_en),
        .fast_from_crystal(fast_from_crystal),
        .sub_clk_en(sub_clk_en),
        .sub_from_crystal(sub_from_crystal),
        .low_freq_rc_clock_en(low_freq_rc_clock_en),
        .internal_fast_en(internal_fast_en),
        .external_fast_crystal_en(external_fast_crystal_en),
        .external_slow_crystal_en(external_slow_crystal_en),
        .internal_fast_freq_select(internal_fast_freq_select)
    );

    // Free-running 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    // Read data only stand in the cycle after the strobe, so compare there
    always @(posedge clock) begin
        if (rd_pend) begin
            if (rd_exp.size() == 0) begin
                check(reg_rdata, 8'hXX);
            end else begin
                check(reg_rdata, rd_exp.pop_front());
            end
        end
        rd_pend = reg_read;
    end

    // Hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc >= LIMIT) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clock);
        rd_exp.push_back(exp);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
    endtask : rd

    task automatic pulse(input logic is_halt);
        @(posedge clock);
        if (is_halt) halt_req <= 1'b1;
        else wake_req <= 1'b1;
        @(posedge clock);
        halt_req <= 1'b0;
        wake_req <= 1'b0;
    endtask : pulse

    // Wait n edges, then step off the edge so registered outputs have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle

    // Distance in cycles between two divided ticks, bounded
    task automatic tick_gap(output int g);
        int k;
        k = 0;
        g = 0;
        while (sys_clk_tick !== 1'b1 && k < 200) begin
            @(posedge clock);
            #1;
            k++;
        end
        do begin
            @(posedge clock);
            #1;
            g++;
        end while (sys_clk_tick !== 1'b1 && g < 200);
    endtask : tick_gap

    initial begin
        int g;
        int c;
        int wd;
        int sel;
        logic [7:0] d;
        rst_n = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        halt_req = 1'b0;
        wake_req = 1'b0;
        watchdog_enable = 1'b0;
        void'($urandom(71));
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        settle(4);
        // State after reset
        check(op_mode, MODE_FAST);
        check(cpu_clk_en, 1'b1);
        check(fast_clk_en, 1'b0);
        rd(ADDR_SYS_CLK_CTRL, SYS_CLK_CTRL_RST);
        rd(ADDR_INT_FAST_CTRL, 8'h03);
        rd(ADDR_EXT_FAST_CTRL, EXT_FAST_CTRL_RST);
        rd(ADDR_EXT_SLOW_CTRL, EXT_SLOW_CTRL_RST);
        // Unused and ready bits ignore writes; ready rises only after start-up
        wr(ADDR_SYS_CLK_CTRL, 8'hFF);
        rd(ADDR_SYS_CLK_CTRL, 8'hEF);
        wr(ADDR_EXT_FAST_CTRL, 8'hFF);
        rd(ADDR_EXT_FAST_CTRL, 8'h05);
        wr(ADDR_EXT_SLOW_CTRL, 8'hFF);
        rd(ADDR_EXT_SLOW_CTRL, 8'h05);
        settle(FAST_XTAL_START_CYC + 4);
        rd(ADDR_EXT_FAST_CTRL, 8'h07);
        settle(SLOW_XTAL_START_CYC - 100);
        rd(ADDR_EXT_SLOW_CTRL, 8'h05);
        settle(200);
        rd(ADDR_EXT_SLOW_CTRL, 8'h07);
        check(external_fast_crystal_en, 1'b1);
        check(external_slow_crystal_en, 1'b1);
        // Every pairing of the two source bits, all oscillators ready
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_SYS_CLK_CTRL, 8'(i << 2));
            settle(3);
            check(fast_from_crystal, i[1] ? 8'h00 : 8'h01);
            check(sub_from_crystal, i[0] ? 8'h00 : 8'h01);
            check(fast_clk_en, 1'b1);
            check(sub_clk_en, 1'b1);
        end
        // Frequency field, random upper bits and ready bit written high
        for (int f = 0; f < 4; f++) begin
            d = {4'($urandom % 16), 2'(f), 2'b11};
            wr(ADDR_INT_FAST_CTRL, d);
            settle(4);
            check(internal_fast_freq_select, 8'(f));
            rd(ADDR_INT_FAST_CTRL, {4'h0, 2'(f), 2'b11});
        end
        // Divider ratios on the internal fast source
        for (int s = 0; s < 7; s++) begin
            wr(ADDR_SYS_CLK_CTRL, 8'((s << 5) | 8));
            settle(4);
            tick_gap(g);
            check(8'(g), 8'(1 << s));
            check(op_mode, MODE_FAST);
        end
        // Slow mode; fast clock then follows its oscillator enable
        wr(ADDR_SYS_CLK_CTRL, 8'hEC);
        settle(3);
        check(op_mode, MODE_SLOW);
        check(sys_on_sub, 1'b1);
        check(cpu_clk_en, 1'b1);
        wr(ADDR_INT_FAST_CTRL, 8'h00);
        settle(3);
        check(fast_clk_en, 1'b0);
        wr(ADDR_INT_FAST_CTRL, 8'h01);
        settle(6);
        check(fast_clk_en, 1'b1);
        // Halt under each idle pairing; sleep both with and without watchdog
        for (int t = 0; t < 5; t++) begin
            c = (t == 0) ? 0 : t - 1;
            wd = (t == 1) ? 1 : ((t == 0) ? 0 : int'($urandom % 2));
            sel = int'($urandom % 7);
            @(posedge clock);
            watchdog_enable <= wd[0];
            wr(ADDR_SYS_CLK_CTRL, 8'((sel << 5) | 12 | c));
            settle(3);
            pulse(1'b1);
            settle(2);
            check(op_mode, exp_mode[c]);
            check(cpu_clk_en, 1'b0);
            check(fast_clk_en, 8'(c >> 1));
            check(sub_clk_en, 8'(c & 1));
            check(low_freq_rc_clock_en, (c == 0 && wd == 0) ? 8'h00 : 8'h01);
            // New idle bits while halted, and a second halt, change nothing
            wr(ADDR_SYS_CLK_CTRL, 8'((sel << 5) | 12 | (c ^ 3)));
            pulse(1'b1);
            settle(2);
            check(op_mode, exp_mode[c]);
            check(fast_clk_en, 8'(c >> 1));
            pulse(1'b0);
            settle(2);
            check(op_mode, MODE_FAST);
            check(cpu_clk_en, 1'b1);
        end
        final_report();
    end
endmodule : test_op_mode_clock_ctrl
`default_nettype wire
